// [verilog/tld_defines.svh]
// Constants for the transaction layer datapath.
// What this block does
// - Message interrupt requests pass registered stages and use request and acknowledge.
// - Adapter FIFO holds a written packet while throttled; empty flag shows it left.
// - Credit vector is 22 bits soft, 36 bits hard; application may ignore it.
// - Each transmit request is credit checked, then acknowledged or held off.
// - Arbitrate among virtual channels and pass the winner to the link layer.
// - With two channels, one channel is high priority and the other low.
// - One or two virtual channels, each with its own receive buffer.
// - Received packets are checked for form, then steered by traffic class map.
// - Each channel keeps posted, non-posted and completion packets in separate regions.
// - Stored packet addresses are queued; a sequencer picks the priority one for delivery.
// - Configuration logic generates messages; downstream ports send slot power toward link.
// - In the hard form every signal between application and layer is registered.
// - Hard form offers a local management bus to the configuration registers.
// - Hard form offers a reconfiguration bus that rewrites read-only configuration values.
// - Non-posted credits count packets pending in the FIFO; others show layer credits.
`ifndef TLD_DEFINES_SVH
`define TLD_DEFINES_SVH
`define TLD_CRED_INIT 6'h08
`define TLD_CRED_FIELD 6
`define TLD_CRED_W_HARD 36
`define TLD_CRED_W_SOFT 22
`define TLD_CFG_TCMAP_IDX 3'h0
`define TLD_CFG_RO_FIRST 3'h4
`define TLD_CFG_RST 32'h0000_00f0
`define TLD_TYPE_MEM 5'h00
`define TLD_TYPE_IO 5'h02
`define TLD_TYPE_CFG0 5'h04
`define TLD_TYPE_CFG1 5'h05
`define TLD_TYPE_CPL 5'h0a
`define TLD_TYPE_MSG_TOP 2'h2
`endif

// [verilog/tld_pkg.sv]
// Types shared by the transaction layer datapath.
package tld_pkg;
  typedef enum logic [1:0] {
    TLD_POSTED = 2'h0, TLD_NONPOSTED = 2'h1, TLD_COMPLETION = 2'h2
  } tld_class_type;
  typedef enum logic [1:0] {TLD_TX_IDLE = 2'h0, TLD_TX_PAYLOAD = 2'h1} tld_tx_state_type;
  typedef enum logic [2:0] {
    TLD_MSG_NONE = 3'h0, TLD_MSG_MSI = 3'h1, TLD_MSG_PME = 3'h2, TLD_MSG_INT = 3'h3,
    TLD_MSG_ERR = 3'h4, TLD_MSG_SPL = 3'h5, TLD_MSG_CFGCPL = 3'h6
  } tld_msg_type;
  typedef struct packed {
    logic valid;
    tld_class_type cls;
    logic [3:0] len;
  } tld_tx_req_type;
  typedef struct packed {
    logic [63:0] word;
    logic sop;
    logic eop;
    logic vc;
    tld_class_type cls;
  } tld_tx_word_type;
  typedef struct packed {
    logic [1:0] fmt;
    logic [4:0] kind;
    logic [2:0] tc;
    logic [63:0] word;
  } tld_rx_pkt_type;
endpackage : tld_pkg

// [verilog/tld_datapath.sv]
// Transaction layer datapath: transmit credit and arbitration, receive buffering, messages.
`timescale 1ns/100ps
`default_nettype none
`include "tld_defines.svh"
module tld_datapath #(
  parameter int HARD_IP = 1,
  parameter int NUM_VC = 2,
  parameter int DEPTH = 16,
  parameter int RX_SLOTS = 4
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire tld_pkg::tld_tx_req_type [1:0] tx_req,
  input wire logic hi_pri_vc,
  output logic [1:0] tx_ack,
  input wire logic [63:0] transmit_stream_word,
  input wire logic tx_word_valid,
  output logic [(HARD_IP != 0 ? `TLD_CRED_W_HARD : `TLD_CRED_W_SOFT)-1:0] tx_cred,
  output logic adapter_fifo_empty_flag,
  output logic [$clog2(DEPTH):0] adapter_fifo_write_pointer,
  output logic [$clog2(DEPTH):0] adapter_fifo_read_pointer,
  input wire logic cred_ret_valid,
  input wire logic cred_ret_vc,
  input wire tld_pkg::tld_class_type cred_ret_cls,
  input wire logic dll_ready,
  output logic dll_valid,
  output tld_pkg::tld_tx_word_type dll_out,
  input wire logic rx_in_valid,
  input wire tld_pkg::tld_rx_pkt_type rx_in,
  output logic rx_malformed,
  output logic rx_overflow,
  output logic rx_valid,
  output logic [2+$clog2(RX_SLOTS):0] rx_addr,
  output logic [63:0] rx_data,
  input wire logic rx_take,
  input wire logic app_msi_req,
  output logic app_msi_ack,
  input wire logic pme_req,
  input wire logic int_req,
  input wire logic err_req,
  input wire logic spl_req,
  input wire logic downstream_port,
  output logic msg_valid,
  output tld_pkg::tld_msg_type msg_kind,
  output logic msg_to_link,
  input wire logic lmi_rden,
  input wire logic lmi_wren,
  input wire logic [2:0] lmi_addr,
  input wire logic [31:0] lmi_din,
  output logic [31:0] lmi_dout,
  output logic lmi_ack,
  input wire logic rcfg_wr,
  input wire logic [2:0] rcfg_addr,
  input wire logic [31:0] rcfg_data
);
  localparam int PW = $clog2(DEPTH) + 1;
  localparam int SW = $clog2(RX_SLOTS);
  localparam int CRED_W = HARD_IP != 0 ? `TLD_CRED_W_HARD : `TLD_CRED_W_SOFT;
  typedef struct packed {
    tld_pkg::tld_tx_state_type tx_st;
    logic tx_vc;
    tld_pkg::tld_class_type tx_cls;
    logic tx_first;
    logic [3:0] tx_rem;
    logic [1:0] tx_ack;
    tld_pkg::tld_tx_word_type [DEPTH-1:0] fifo;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic fifo_empty;
    logic [1:0][2:0][5:0] lcred;
    logic [1:0][2:0][PW-1:0] pend;
    logic [CRED_W-1:0] cred;
    logic dll_valid;
    tld_pkg::tld_tx_word_type dll_out;
    logic [1:0][2:0][RX_SLOTS-1:0][63:0] rxmem;
    logic [1:0][2:0][SW:0] rwp;
    logic [1:0][2:0][SW:0] rrp;
    logic rx_valid;
    logic [63:0] rx_data;
    logic [2+SW:0] rx_addr;
    logic rx_bad;
    logic rx_ovf;
    logic msi_s;
    logic msi_busy;
    logic [6:0] mpend;
    logic msg_valid;
    tld_pkg::tld_msg_type msg_kind;
    logic msg_to_link;
    logic msi_ack;
    logic [7:0][31:0] cfg;
    logic lmi_ack;
    logic [31:0] lmi_dout;
  } tld_state_type;

  tld_state_type s_q;
  tld_state_type s_d;

  // Returns {malformed, class} for a received header.
  function automatic logic [2:0] tld_decode(input tld_pkg::tld_rx_pkt_type p);
    logic [2:0] r;
    r = {1'b0, tld_pkg::TLD_NONPOSTED};
    case (p.kind)
      `TLD_TYPE_MEM: r = {1'b0, p.fmt[1] ? tld_pkg::TLD_POSTED : tld_pkg::TLD_NONPOSTED};
      `TLD_TYPE_IO, `TLD_TYPE_CFG0, `TLD_TYPE_CFG1: r = {1'b0, tld_pkg::TLD_NONPOSTED};
      `TLD_TYPE_CPL: r = {1'b0, tld_pkg::TLD_COMPLETION};
      default: r = (p.kind[4:3] == `TLD_TYPE_MSG_TOP) ? {1'b0, tld_pkg::TLD_POSTED} : 3'h4;
    endcase
    return r;
  endfunction : tld_decode

  always_comb begin
    tld_state_type n;
    tld_pkg::tld_tx_req_type req;
    tld_pkg::tld_tx_word_type head;
    logic sel;
    logic found;
    logic rvc;
    logic [2:0] dec;
    logic [PW-1:0] used;
    logic [35:0] full;
    n = s_q;
    req = tx_req[0];
    head = s_q.fifo[s_q.rp[PW-2:0]];
    sel = 1'b0;
    found = 1'b0;
    rvc = 1'b0;
    dec = 3'h0;
    used = s_q.wp - s_q.rp;
    full = '0;
    n.tx_ack = 2'h0;
    n.rx_bad = 1'b0;
    n.rx_ovf = 1'b0;
    n.msg_valid = 1'b0;
    n.msg_kind = tld_pkg::TLD_MSG_NONE;
    n.msg_to_link = 1'b0;
    n.msi_ack = 1'b0;
    n.lmi_ack = 1'b0;
    // ************************************************************
    // Transmit request grant and payload capture.
    // ************************************************************
    if (tx_req[0].valid && tx_req[1].valid && NUM_VC == 2) begin
      sel = hi_pri_vc;
    end else begin
      sel = tx_req[1].valid && NUM_VC == 2;
    end
    req = tx_req[sel];
    unique case (s_q.tx_st)
      tld_pkg::TLD_TX_IDLE: begin
        // Credits are spent when a packet leaves the FIFO, so pending ones are subtracted.
        if (req.valid && req.len != 4'h0 && s_q.lcred[sel][req.cls] > 6'(s_q.pend[sel][req.cls])
            && int'(used) + int'(req.len) <= DEPTH) begin
          n.tx_ack[sel] = 1'b1;
          n.tx_vc = sel;
          n.tx_cls = req.cls;
          n.tx_rem = req.len;
          n.tx_first = 1'b1;
          n.pend[sel][req.cls] = s_q.pend[sel][req.cls] + 1'b1;
          n.tx_st = tld_pkg::TLD_TX_PAYLOAD;
        end
      end
      tld_pkg::TLD_TX_PAYLOAD: begin
        // Room was reserved at grant, so a consecutive payload never overruns.
        if (tx_word_valid) begin
          n.fifo[s_q.wp[PW-2:0]] = '{word: transmit_stream_word, sop: s_q.tx_first,
                                     eop: s_q.tx_rem == 4'h1, vc: s_q.tx_vc, cls: s_q.tx_cls};
          n.wp = s_q.wp + 1'b1;
          n.tx_first = 1'b0;
          n.tx_rem = s_q.tx_rem - 4'h1;
          if (s_q.tx_rem == 4'h1) begin
            n.tx_st = tld_pkg::TLD_TX_IDLE;
          end
        end
      end
    endcase
    // ************************************************************
    // FIFO drain toward the link layer.
    // ************************************************************
    if (s_q.wp != s_q.rp && dll_ready) begin
      n.dll_out = head;
      n.dll_valid = 1'b1;
      n.rp = s_q.rp + 1'b1;
      if (head.eop) begin
        n.lcred[head.vc][head.cls] = n.lcred[head.vc][head.cls] - 6'h01;
        n.pend[head.vc][head.cls] = n.pend[head.vc][head.cls] - 1'b1;
      end
    end else if (dll_ready) begin
      n.dll_valid = 1'b0;
    end
    if (cred_ret_valid) begin
      n.lcred[cred_ret_vc][cred_ret_cls] = n.lcred[cred_ret_vc][cred_ret_cls] + 6'h01;
    end
    n.fifo_empty = n.wp == n.rp;
    for (int v = 0; v < 2; v++) begin
      for (int c = 0; c < 3; c++) begin
        full[(v*3+c)*`TLD_CRED_FIELD +: `TLD_CRED_FIELD] = (c == 1) ?
          n.lcred[v][c] - 6'(n.pend[v][c]) : n.lcred[v][c];
      end
    end
    n.cred = full[CRED_W-1:0];
    // ************************************************************
    // Receive check, steering, storage and sequencing.
    // ************************************************************
    if (rx_in_valid) begin
      dec = tld_decode(rx_in);
      rvc = s_q.cfg[`TLD_CFG_TCMAP_IDX][rx_in.tc] && NUM_VC == 2;
      if (dec[2]) begin
        n.rx_bad = 1'b1;
      end else if (s_q.rwp[rvc][dec[1:0]] - s_q.rrp[rvc][dec[1:0]] == (SW+1)'(RX_SLOTS)) begin
        n.rx_ovf = 1'b1;
      end else begin
        n.rxmem[rvc][dec[1:0]][s_q.rwp[rvc][dec[1:0]][SW-1:0]] = rx_in.word;
        n.rwp[rvc][dec[1:0]] = s_q.rwp[rvc][dec[1:0]] + 1'b1;
        if (rx_in.kind == `TLD_TYPE_CFG0 || rx_in.kind == `TLD_TYPE_CFG1) begin
          n.mpend[tld_pkg::TLD_MSG_CFGCPL] = 1'b1;
        end
      end
    end
    // Posted traffic may pass completions and requests; the priority channel goes first.
    if (!s_q.rx_valid || rx_take) begin
      n.rx_valid = 1'b0;
      for (int k = 0; k < NUM_VC; k++) begin
        for (int j = 0; j < 3; j++) begin
          rvc = (NUM_VC == 2) ? (k[0] ^ hi_pri_vc) : 1'b0;
          dec[1:0] = (j == 0) ? 2'h0 : 2'(3 - j);
          if (!found && s_q.rwp[rvc][dec[1:0]] != s_q.rrp[rvc][dec[1:0]]) begin
            found = 1'b1;
            n.rx_valid = 1'b1;
            n.rx_data = s_q.rxmem[rvc][dec[1:0]][s_q.rrp[rvc][dec[1:0]][SW-1:0]];
            n.rx_addr = {rvc, dec[1:0], s_q.rrp[rvc][dec[1:0]][SW-1:0]};
            n.rrp[rvc][dec[1:0]] = s_q.rrp[rvc][dec[1:0]] + 1'b1;
          end
        end
      end
    end
    // ************************************************************
    // Message generation and the interrupt handshake.
    // ************************************************************
    n.msi_s = app_msi_req;
    found = 1'b0;
    for (int m = 1; m < 7; m++) begin
      if (!found && s_q.mpend[m]) begin
        found = 1'b1;
        n.mpend[m] = 1'b0;
        n.msg_valid = 1'b1;
        n.msg_kind = tld_pkg::tld_msg_type'(m);
        n.msg_to_link = (m == 5) && downstream_port;
        n.msi_ack = m == 1;
      end
    end
    // Sets other than the configuration completion one follow clears so an event in the clearing cycle survives.
    if (s_q.msi_s && !s_q.msi_busy) begin
      n.mpend[tld_pkg::TLD_MSG_MSI] = 1'b1;
      n.msi_busy = 1'b1;
    end else if (!s_q.msi_s) begin
      n.msi_busy = 1'b0;
    end
    n.mpend[5:2] = n.mpend[5:2] | {spl_req, err_req, int_req, pme_req};
    // ************************************************************
    // Local management and reconfiguration access.
    // ************************************************************
    if (HARD_IP != 0) begin
      if (lmi_rden || lmi_wren) begin
        n.lmi_ack = 1'b1;
        n.lmi_dout = s_q.cfg[lmi_addr];
        if (lmi_wren && lmi_addr < `TLD_CFG_RO_FIRST) begin
          n.cfg[lmi_addr] = lmi_din;
        end
      end
      if (rcfg_wr) begin
        n.cfg[rcfg_addr] = rcfg_data;
      end
    end
    if (!rst_b) begin
      n = '0;
      n.lcred = {6{`TLD_CRED_INIT}};
      n.cfg[`TLD_CFG_TCMAP_IDX] = `TLD_CFG_RST;
      n.fifo_empty = 1'b1;
      n.cred = '0;
    end
    s_d = n;
  end

  always_ff @(posedge core_clk) begin
    s_q <= s_d;
  end

  // Every output is a field of the registered state.
  assign tx_ack = s_q.tx_ack;
  assign tx_cred = s_q.cred;
  assign adapter_fifo_empty_flag = s_q.fifo_empty;
  assign adapter_fifo_write_pointer = s_q.wp;
  assign adapter_fifo_read_pointer = s_q.rp;
  assign dll_valid = s_q.dll_valid;
  assign dll_out = s_q.dll_out;
  assign rx_malformed = s_q.rx_bad;
  assign rx_overflow = s_q.rx_ovf;
  assign rx_valid = s_q.rx_valid;
  assign rx_addr = s_q.rx_addr;
  assign rx_data = s_q.rx_data;
  assign app_msi_ack = s_q.msi_ack;
  assign msg_valid = s_q.msg_valid;
  assign msg_kind = s_q.msg_kind;
  assign msg_to_link = s_q.msg_to_link;
  assign lmi_dout = s_q.lmi_dout;
  assign lmi_ack = s_q.lmi_ack;

  // ************************************************************
  // Checks.
  // ************************************************************
  default clocking tld_cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_msi_ack_cause: assert property (app_msi_ack |-> $past(app_msi_req, 2))
    else $error("message acknowledge without a request");
  a_fifo_hold: assert property (dll_valid && !dll_ready |=> dll_valid && $stable(dll_out))
    else $error("link output changed while throttled");
  a_empty_flag: assert property (adapter_fifo_empty_flag
    == (adapter_fifo_write_pointer == adapter_fifo_read_pointer))
    else $error("empty flag disagrees with pointers");
  a_ack_credit: assert property (tx_ack[0] |-> $past(tx_req[0].valid)
    && $past(s_q.lcred[0][tx_req[0].cls]) > 6'($past(s_q.pend[0][tx_req[0].cls])))
    else $error("grant without credit");
  a_ack_single: assert property ($onehot0(tx_ack) && !(NUM_VC == 1 && tx_ack[1]))
    else $error("more than one grant");
  a_arb_priority: assert property (tx_ack[!hi_pri_vc] && NUM_VC == 2
    |-> !$past(tx_req[hi_pri_vc].valid) || $past(hi_pri_vc) != hi_pri_vc)
    else $error("low priority channel won over high");
  a_rx_malformed: assert property (rx_malformed |-> $past(rx_in_valid))
    else $error("malformed flag without a packet");
  a_rx_region: assert property (rx_valid && !$past(rx_valid) |-> rx_addr[SW+1:SW] != 2'h3)
    else $error("delivered address outside class regions");
  a_lmi_answer: assert property ((lmi_rden || lmi_wren) && HARD_IP != 0 |=> lmi_ack)
    else $error("management access not answered");
  a_spl_link: assert property (msg_to_link |-> msg_valid
    && msg_kind == tld_pkg::TLD_MSG_SPL)
    else $error("link message of wrong kind");
  c_tx_packet: cover property (tx_ack[0] ##[1:8] dll_valid && dll_out.eop);
  c_rx_deliver: cover property (rx_in_valid ##[1:4] rx_valid);
  c_msi_done: cover property (app_msi_req ##[2:6] app_msi_ack);
endmodule : tld_datapath
`default_nettype wire

// [bench/tld_app_model.sv]
// Application-side receive consumer with a stall control.
`timescale 1ns/100ps
`default_nettype none
module tld_app_model (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic stall,
  input wire logic rx_valid,
  input wire logic [4:0] rx_addr,
  input wire logic [63:0] rx_data,
  output logic rx_take,
  output logic got,
  output logic [4:0] got_addr,
  output logic [63:0] got_data
);
  initial rx_take = 1'b0;
  // The take is driven off the sampling edge so it never races rx_valid.
  always @(negedge core_clk) begin
    rx_take <= rx_valid && !stall;
  end
  always_ff @(posedge core_clk) begin
    got <= rst_b && rx_take && rx_valid;
    if (rx_take && rx_valid) begin
      got_addr <= rx_addr;
      got_data <= rx_data;
    end
  end
endmodule : tld_app_model
`default_nettype wire

// [bench/tld_datapath_test.sv]
// Self-checking testbench for the transaction layer datapath.
`timescale 1ns/100ps
`default_nettype none
`include "tld_defines.svh"
module tld_datapath_test;
  // ********************************
  // Signals and instances
  // ********************************
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  tld_pkg::tld_tx_req_type [1:0] tx_req = '0;
  logic hi_pri_vc = 1'b0, tx_word_valid = 1'b0, dll_ready = 1'b0, stall = 1'b0;
  logic [63:0] transmit_stream_word = '0;
  logic cred_ret_valid = 1'b0, cred_ret_vc = 1'b0;
  tld_pkg::tld_class_type cred_ret_cls = tld_pkg::TLD_POSTED;
  logic rx_in_valid = 1'b0, app_msi_req = 1'b0, downstream_port = 1'b0;
  tld_pkg::tld_rx_pkt_type rx_in = '0;
  logic pme_req = 1'b0, int_req = 1'b0, err_req = 1'b0, spl_req = 1'b0;
  logic lmi_rden = 1'b0, lmi_wren = 1'b0, rcfg_wr = 1'b0;
  logic [2:0] lmi_addr = '0, rcfg_addr = '0;
  logic [31:0] lmi_din = '0, rcfg_data = '0, lmi_dout;
  logic [1:0] tx_ack;
  logic [35:0] tx_cred;
  logic [4:0] wp, rp, rx_addr, got_addr;
  logic empty, dll_valid, rx_malformed, rx_overflow, rx_valid, rx_take, got;
  logic app_msi_ack, msg_valid, msg_to_link, lmi_ack;
  logic [63:0] rx_data, got_data;
  tld_pkg::tld_tx_word_type dll_out;
  tld_pkg::tld_msg_type msg_kind;
  int mismatches = 0;
  int n_tests = 0;
  always #25 core_clk = ~core_clk;
  tld_datapath dut_u (.core_clk(core_clk), .rst_b(rst_b), .tx_req(tx_req),
    .hi_pri_vc(hi_pri_vc), .tx_ack(tx_ack), .transmit_stream_word(transmit_stream_word),
    .tx_word_valid(tx_word_valid), .tx_cred(tx_cred), .adapter_fifo_empty_flag(empty),
    .adapter_fifo_write_pointer(wp), .adapter_fifo_read_pointer(rp),
    .cred_ret_valid(cred_ret_valid), .cred_ret_vc(cred_ret_vc), .cred_ret_cls(cred_ret_cls),
    .dll_ready(dll_ready), .dll_valid(dll_valid), .dll_out(dll_out),
    .rx_in_valid(rx_in_valid), .rx_in(rx_in), .rx_malformed(rx_malformed),
    .rx_overflow(rx_overflow), .rx_valid(rx_valid), .rx_addr(rx_addr), .rx_data(rx_data),
    .rx_take(rx_take), .app_msi_req(app_msi_req), .app_msi_ack(app_msi_ack),
    .pme_req(pme_req), .int_req(int_req), .err_req(err_req), .spl_req(spl_req),
    .downstream_port(downstream_port), .msg_valid(msg_valid), .msg_kind(msg_kind),
    .msg_to_link(msg_to_link), .lmi_rden(lmi_rden), .lmi_wren(lmi_wren),
    .lmi_addr(lmi_addr), .lmi_din(lmi_din), .lmi_dout(lmi_dout), .lmi_ack(lmi_ack),
    .rcfg_wr(rcfg_wr), .rcfg_addr(rcfg_addr), .rcfg_data(rcfg_data));
  tld_app_model app_u (.core_clk(core_clk), .rst_b(rst_b), .stall(stall),
    .rx_valid(rx_valid), .rx_addr(rx_addr), .rx_data(rx_data), .rx_take(rx_take),
    .got(got), .got_addr(got_addr), .got_data(got_data));
  // ********************************
  // Shared tasks
  // ********************************
  task tick;
    @(negedge core_clk);
  endtask : tick
  task complete_run;
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  task chk(input logic [63:0] g, input logic [63:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : chk
  task lim(input int i, input int n);
    if (i >= n) begin
      mismatches++;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      complete_run;
    end
  endtask : lim
  // The whole payload follows the grant on consecutive cycles.
  task send(input logic v, input tld_pkg::tld_class_type c, input logic [3:0] n);
    int i;
    tx_req[v] = '{1'b1, c, n};
    for (i = 0; i < 60 && tx_ack[v] !== 1'b1; i++) tick;
    lim(i, 60);
    tx_req[v] = '0;
    for (i = 0; i < n; i++) begin
      transmit_stream_word = 64'ha0 + i;
      tx_word_valid = 1'b1;
      tick;
    end
    tx_word_valid = 1'b0;
  endtask : send
  task wait_empty;
    int i;
    for (i = 0; i < 80 && empty !== 1'b1; i++) tick;
    lim(i, 80);
  endtask : wait_empty
  task rxp(input logic [1:0] f, input logic [4:0] k, input logic [2:0] t, input logic [63:0] w);
    rx_in = '{f, k, t, w};
    rx_in_valid = 1'b1;
    tick;
  endtask : rxp
  task wait_got;
    int i;
    for (i = 0; i < 20 && got !== 1'b1; i++) tick;
    lim(i, 20);
  endtask : wait_got
  task local_management_bus(input logic w, input logic [2:0] a, input logic [31:0] d, output logic [31:0] rd);
    int i;
    lmi_wren = w;
    lmi_rden = !w;
    lmi_addr = a;
    lmi_din = d;
    tick;
    lmi_wren = 1'b0;
    lmi_rden = 1'b0;
    for (i = 0; i < 4 && lmi_ack !== 1'b1; i++) tick;
    lim(i, 4);
    rd = lmi_dout;
    tick;
  endtask : local_management_bus
  // ********************************
  // Scenarios
  // ********************************
  task s_reset;
    repeat (4) tick;
    chk(empty, 1'b1, "empty flag at reset");
    chk(dll_valid, 1'b0, "link valid at reset");
    rst_b = 1'b1;
    tick;
    chk(tx_cred, {6{`TLD_CRED_INIT}}, "credit vector after reset");
    chk($bits(tx_cred), 36, "credit vector width");
  endtask : s_reset
  task s_fifo;
    int i;
    send(1'b0, tld_pkg::TLD_NONPOSTED, 4'hf);
    repeat (3) tick;
    chk(wp, 5'h0f, "write pointer after fill");
    chk(rp, 5'h00, "read pointer while throttled");
    chk(empty, 1'b0, "packet held while throttled");
    chk(tx_cred[11:6], 6'h07, "non-posted field counts pending");
    chk(tx_cred[5:0], 6'h08, "posted field shows layer credits");
    tx_req[0] = '{1'b1, tld_pkg::TLD_POSTED, 4'h2};
    for (i = 0; i < 10; i++) begin
      tick;
      chk(tx_ack, 2'h0, "grant without room");
    end
    dll_ready = 1'b1;
    for (i = 0; i < 20 && dll_valid !== 1'b1; i++) tick;
    lim(i, 20);
    chk(dll_out.sop, 1'b1, "first word start");
    chk(dll_out.word, 64'ha0, "first word value");
    chk(dll_out.cls, tld_pkg::TLD_NONPOSTED, "first word class");
    send(1'b0, tld_pkg::TLD_POSTED, 4'h2);
    wait_empty;
    repeat (3) tick;
    chk(tx_cred[11:0], {6'h07, 6'h07}, "credits consumed");
    cred_ret_valid = 1'b1;
    cred_ret_cls = tld_pkg::TLD_NONPOSTED;
    tick;
    cred_ret_cls = tld_pkg::TLD_POSTED;
    tick;
    cred_ret_valid = 1'b0;
    repeat (3) tick;
    chk(tx_cred[11:0], {2{`TLD_CRED_INIT}}, "credits returned");
    chk(wp, 5'h11, "write pointer after traffic");
    chk(rp, 5'h11, "read pointer after drain");
  endtask : s_fifo
  task s_arb;
    int p;
    int i;
    for (p = 0; p < 2; p++) begin
      hi_pri_vc = p[0];
      tx_req[0] = '{1'b1, tld_pkg::TLD_POSTED, 4'h1};
      tx_req[1] = '{1'b1, tld_pkg::TLD_POSTED, 4'h1};
      for (i = 0; i < 20 && tx_ack === 2'h0; i++) tick;
      lim(i, 20);
      chk(tx_ack, p[0] ? 2'h2 : 2'h1, "priority channel first");
      send(p[0], tld_pkg::TLD_POSTED, 4'h1);
      send(!p[0], tld_pkg::TLD_POSTED, 4'h1);
    end
    wait_empty;
  endtask : s_arb
  task s_msg;
    int k;
    int i;
    downstream_port = 1'b1;
    {pme_req, int_req, err_req, spl_req} = 4'hf;
    tick;
    {pme_req, int_req, err_req, spl_req} = 4'h0;
    for (k = 0; k < 4; k++) begin
      for (i = 0; i < 10 && msg_valid !== 1'b1; i++) tick;
      lim(i, 10);
      chk(msg_kind, 64'h2 + k, "message order");
      chk(msg_to_link, k == 3, "slot power toward link");
      tick;
    end
  endtask : s_msg
  task s_msi;
    int i;
    wait_empty;
    app_msi_req = 1'b1;
    for (i = 0; i < 10 && app_msi_ack !== 1'b1; i++) tick;
    lim(i, 10);
    chk(i >= 3, 1'b1, "registered request stages");
    app_msi_req = 1'b0;
    tick;
  endtask : s_msi
  task s_rx;
    int k;
    int i;
    // The first packet is presented at once; the three behind it queue and get reordered.
    logic [63:0] ed [4] = '{64'h11, 64'h66, 64'h22, 64'h33};
    logic [1:0] ec [4] = '{2'h1, 2'h0, 2'h0, 2'h2};
    logic ev [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
    hi_pri_vc = 1'b1;
    stall = 1'b1;
    rxp(2'h0, `TLD_TYPE_MEM, 3'h0, 64'h11);
    rxp(2'h0, `TLD_TYPE_CPL, 3'h0, 64'h33);
    rxp(2'h2, `TLD_TYPE_MEM, 3'h0, 64'h22);
    rxp(2'h2, `TLD_TYPE_MEM, 3'h4, 64'h66);
    rx_in_valid = 1'b0;
    repeat (4) tick;
    stall = 1'b0;
    for (k = 0; k < 4; k++) begin
      wait_got;
      chk(got_addr[3:2], ec[k], "receive region");
      chk(got_data, ed[k], "receive reorder");
      chk(got_addr[4], ev[k], "priority channel delivered first");
      tick;
    end
    rxp(2'h2, `TLD_TYPE_MEM, 3'h4, 64'h44);
    rx_in_valid = 1'b0;
    wait_got;
    chk(got_addr[4], 1'b1, "class map steering");
    chk(got_data, 64'h44, "second channel buffer");
    rxp(2'h0, `TLD_TYPE_CFG0, 3'h0, 64'h77);
    rx_in_valid = 1'b0;
    for (i = 0; i < 5 && msg_valid !== 1'b1; i++) tick;
    lim(i, 5);
    chk(msg_kind, tld_pkg::TLD_MSG_CFGCPL, "configuration completion message");
    wait_got;
    chk(got_data, 64'h77, "configuration request delivered");
    stall = 1'b1;
    for (k = 0; k < 6; k++) begin
      rxp(2'h2, `TLD_TYPE_MEM, 3'h0, 64'h70 + k);
    end
    rx_in_valid = 1'b0;
    chk(rx_overflow, 1'b1, "full posted queue refuses a packet");
    stall = 1'b0;
    for (k = 0; k < 5; k++) begin
      wait_got;
      chk(got_data, 64'h70 + k, "queued packets drained in order");
      tick;
    end
    rxp(2'h2, 5'h1f, 3'h0, 64'h55);
    rx_in_valid = 1'b0;
    for (i = 0; i < 5 && rx_malformed !== 1'b1; i++) tick;
    chk(i < 5, 1'b1, "malformed packet flagged");
  endtask : s_rx
  task s_lmi;
    logic [31:0] rd;
    local_management_bus(1'b0, 3'h0, 32'h0, rd);
    chk(rd, `TLD_CFG_RST, "map register reset");
    rcfg_wr = 1'b1;
    rcfg_addr = 3'h5;
    rcfg_data = 32'h0000_1234;
    local_management_bus(1'b1, 3'h5, 32'h0000_5678, rd);
    rcfg_wr = 1'b0;
    local_management_bus(1'b0, 3'h5, 32'h0, rd);
    chk(rd, 32'h0000_1234, "read-only value rewritten");
    local_management_bus(1'b1, 3'h6, 32'h0000_5678, rd);
    local_management_bus(1'b0, 3'h6, 32'h0, rd);
    chk(rd, 32'h0, "management write to read-only refused");
    local_management_bus(1'b1, 3'h1, 32'h0000_abcd, rd);
    local_management_bus(1'b0, 3'h1, 32'h0, rd);
    chk(rd, 32'h0000_abcd, "management write and read");
  endtask : s_lmi
  initial begin
    s_reset;
    s_fifo;
    s_arb;
    s_msg;
    s_msi;
    s_rx;
    s_lmi;
    complete_run;
  end
endmodule : tld_datapath_test
`default_nettype wire
